// ---- verilog/bsrr_status_report.sv ----
`timescale 1ns/10ps

module bsrr_status_report #(
    parameter int CMD_DEPTH  = bsrr_pkg::CMD_DEPTH,
    parameter int DATA_DEPTH = bsrr_pkg::DATA_DEPTH,
    parameter int RES_SLOTS  = bsrr_pkg::RES_SLOTS
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Command engine state.
    input  wire logic       cmd_busy,
    input  wire logic [7:0] cmd_byte_low,
    input  wire logic [7:0] cmd_byte_high,
    // Queue events from the data path.
    input  wire logic       cmd_push,
    input  wire logic       cmd_pop,
    input  wire logic       out_push,
    input  wire logic       out_pop,
    input  wire logic       in_push,
    input  wire logic       in_pop,
    // Control endpoint events.
    input  wire logic       setup_arrive,
    input  wire logic       ctrl_fifo_full,
    input  wire logic       device_reset_request,
    // Command completion report.
    input  wire logic       cmd_done,
    input  wire logic [2:0] done_kind,
    input  wire logic       notify_result_bit,
    input  wire logic       result_control_bit,
    input  wire logic       ev_no_presence,
    input  wire logic       ev_short,
    input  wire logic       ev_alarm,
    input  wire logic       ev_crc_bad,
    input  wire logic       ev_redirect,
    input  wire logic       ev_compare,
    input  wire logic       ev_search_early,
    input  wire logic       device_detect,
    // Interrupt endpoint report read port.
    input  wire logic       poll_start,
    input  wire logic       rd_en,
    input  wire logic [4:0] rd_addr,
    output logic [7:0]      rd_data,
    output logic            rd_valid,
    output logic [4:0]      report_len,
    output logic            setup_accept,
    output logic            setup_overflow_flag
);
    initial begin
        if (CMD_DEPTH > 255 || DATA_DEPTH > 255 || CMD_DEPTH < 1 || DATA_DEPTH < 1) begin
            $error("Queue depths must fit an 8-bit level");
        end
        if (RES_SLOTS != 16) begin
            $error("Result window is 16 bytes");
        end
    end

    // ==========================================================
    // Fill level tracking.
    // ==========================================================
    // Steps a level up or down, saturating at the queue bounds.
    function automatic logic [7:0] bsrr_step(input logic [7:0] lvl, input logic up,
                                             input logic dn, input logic [7:0] top);
        logic [7:0] r;
        r = lvl;
        if (up && !dn && lvl < top) begin
            r = lvl + 8'h01;
        end else if (dn && !up && lvl != 8'h00) begin
            r = lvl - 8'h01;
        end
        return r;
    endfunction : bsrr_step

    localparam logic [7:0] CMD_TOP  = 8'(CMD_DEPTH);   // Command queue capacity.
    localparam logic [7:0] DATA_TOP = 8'(DATA_DEPTH);  // Data queue capacity.

    logic [7:0] command_queue_level;   // Bytes in the command queue.
    logic [7:0] outbound_queue_level;  // Bytes waiting for the bus.
    logic [7:0] inbound_queue_level;   // Bytes read back from the bus.

    wire [7:0] next_cmd_level = bsrr_step(command_queue_level, cmd_push, cmd_pop, CMD_TOP);
    wire [7:0] next_out_level = bsrr_step(outbound_queue_level, out_push, out_pop, DATA_TOP);
    wire [7:0] next_in_level  = bsrr_step(inbound_queue_level, in_push, in_pop, DATA_TOP);

    // The levels mirror the queues; a device reset empties everything.
    always_ff @(posedge core_clk) begin
        if (!nrst || device_reset_request) begin
            command_queue_level  <= 8'h00;
            outbound_queue_level <= 8'h00;
            inbound_queue_level  <= 8'h00;
        end else begin
            command_queue_level  <= next_cmd_level;
            outbound_queue_level <= next_out_level;
            inbound_queue_level  <= next_in_level;
        end
    end

    // ==========================================================
    // Active command registers.
    // ==========================================================
    logic [7:0] active_command_low;   // First byte of the running command.
    logic [7:0] active_command_high;  // Second byte of the running command.

    wire [7:0] next_cmd_low  = cmd_busy ? cmd_byte_low : bsrr_pkg::IDLE_VALUE;
    wire [7:0] next_cmd_high = cmd_busy ? cmd_byte_high : bsrr_pkg::IDLE_VALUE;

    // Idle reads as zero so the host never sees a stale command.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            active_command_low  <= bsrr_pkg::IDLE_VALUE;
            active_command_high <= bsrr_pkg::IDLE_VALUE;
        end else begin
            active_command_low  <= next_cmd_low;
            active_command_high <= next_cmd_high;
        end
    end

    // ==========================================================
    // Setup overflow handling.
    // ==========================================================
    // A device reset request is honoured even while overflowed, so the
    // overflow test ignores it; the set wins over a simultaneous clear.
    wire setup_drop  = setup_arrive && ctrl_fifo_full;
    wire next_accept = setup_arrive && !ctrl_fifo_full;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            setup_overflow_flag <= 1'b0;
            setup_accept        <= 1'b0;
        end else begin
            setup_accept <= next_accept;
            if (setup_drop) begin
                setup_overflow_flag <= 1'b1;
            end else if (device_reset_request) begin
                setup_overflow_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Result byte generation.
    // ==========================================================
    // All conditions but compare are gated by the finished command's kind,
    // so their unrelated strobes cannot leak in; compare passes ungated.
    wire k_reset  = (done_kind == bsrr_pkg::BSRR_K_RESET);
    wire k_path   = (done_kind == bsrr_pkg::BSRR_K_PATH);
    wire k_search = (done_kind == bsrr_pkg::BSRR_K_SEARCH);
    wire k_redir  = (done_kind == bsrr_pkg::BSRR_K_RDREDIR);
    wire k_crc    = (done_kind == bsrr_pkg::BSRR_K_WRPAGE) ||
                    (done_kind == bsrr_pkg::BSRR_K_RDCRC) || k_redir;

    wire f_nopres = ev_no_presence && (k_reset || k_path || k_search);
    wire f_short  = ev_short && (k_reset || k_path);
    wire f_redir  = ev_redirect && k_redir;
    wire f_crc    = ev_crc_bad && k_crc;
    wire f_alarm  = ev_alarm && k_reset;
    wire f_eos    = ev_search_early && k_search;

    wire [7:0] error_byte;
    assign error_byte[bsrr_pkg::BIT_EOS]    = f_eos;
    assign error_byte[bsrr_pkg::BIT_RDP]    = f_redir;
    assign error_byte[bsrr_pkg::BIT_CRC]    = f_crc;
    assign error_byte[bsrr_pkg::BIT_CMP]    = ev_compare;
    assign error_byte[bsrr_pkg::BIT_ZERO]   = 1'b0;
    assign error_byte[bsrr_pkg::BIT_APP]    = f_alarm;
    assign error_byte[bsrr_pkg::BIT_SHORT]  = f_short;
    assign error_byte[bsrr_pkg::BIT_NOPRES] = f_nopres;

    // A result is queued when notify is set, or when the command failed
    // and result control asks for error results; clean bits stay zero.
    wire any_error  = (error_byte != 8'h00);
    wire want_res   = cmd_done && (notify_result_bit || (result_control_bit && any_error));
    wire detect_ev  = device_detect;

    // Detect and result bytes share one queue; detect has priority in
    // a shared cycle and the result follows in the next cycle without a detect.
    logic       held_valid;  // Result byte waiting behind a detect byte.
    logic [7:0] held_byte;   // The waiting result byte.

    wire        q_push = detect_ev || held_valid || want_res;
    wire [7:0]  q_data = detect_ev ? bsrr_pkg::DETECT_BYTE :
                         (held_valid ? held_byte : error_byte);
    // A held byte survives a second detect; a third byte in that one
    // cycle has no slot and is lost, a limit of the single hold stage.
    wire        next_held_valid = detect_ev ? (held_valid || want_res) :
                                  (held_valid && want_res);
    wire [7:0]  next_held_byte  = (detect_ev && held_valid) ? held_byte :
                                  (want_res ? error_byte : held_byte);

    always_ff @(posedge core_clk) begin
        if (!nrst || device_reset_request) begin
            held_valid <= 1'b0;
            held_byte  <= 8'h00;
        end else begin
            held_valid <= next_held_valid;
            held_byte  <= next_held_byte;
        end
    end

    // ==========================================================
    // Result queue and per-poll snapshot.
    // ==========================================================
    logic [7:0] q_head;
    logic       q_empty;
    logic       q_full;
    logic       q_pop;
    logic       q_pop_r;

    bsrr_result_queue #(
        .DEPTH (RES_SLOTS)
    ) u_queue (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .clear     (device_reset_request),
        .push      (q_push),
        .push_data (q_data),
        .pop       (q_pop),
        .head      (q_head),
        .empty     (q_empty),
        .full      (q_full)
    );

    // On a poll the queue drains into the report window, oldest first,
    // so each byte is sent once and in completion order.
    logic [7:0] snap [16];   // Report window bytes.
    logic       draining;    // Queue drain in progress.
    logic [4:0] fill;        // Bytes captured so far.

    assign q_pop = draining && !q_empty && (fill < 5'd16) && !q_pop_r;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            draining   <= 1'b0;
            fill       <= 5'd0;
            report_len <= 5'd0;
            q_pop_r    <= 1'b0;
        end else begin
            q_pop_r <= 1'b0;
            if (poll_start) begin
                draining <= 1'b1;
                fill     <= 5'd0;
            end else if (q_pop) begin
                snap[fill[3:0]] <= q_head;
                fill            <= fill + 5'd1;
                report_len      <= fill + 5'd1;
                q_pop_r         <= 1'b1;
            end else if (draining && !q_pop_r) begin
                draining   <= 1'b0;
                report_len <= fill;
            end
        end
    end

    // ==========================================================
    // Report read port.
    // ==========================================================
    wire        in_results = (rd_addr >= bsrr_pkg::OFS_RES_FIRST);
    wire [3:0]  res_idx    = rd_addr[3:0];
    wire        res_live   = in_results && ({1'b0, res_idx} < fill);
    logic [7:0] next_rd_data;

    always_comb begin
        next_rd_data = bsrr_pkg::ZERO_BYTE;
        case (rd_addr)
            bsrr_pkg::OFS_CMD_LOW:   next_rd_data = active_command_low;
            bsrr_pkg::OFS_CMD_HIGH:  next_rd_data = active_command_high;
            bsrr_pkg::OFS_CMD_LEVEL: next_rd_data = command_queue_level;
            bsrr_pkg::OFS_OUT_LEVEL: next_rd_data = outbound_queue_level;
            bsrr_pkg::OFS_IN_LEVEL:  next_rd_data = inbound_queue_level;
            default: begin
                if (res_live) begin
                    next_rd_data = snap[res_idx];
                end
            end
        endcase
    end

    // Read data is registered, one cycle after the enable.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            rd_data  <= rd_en ? next_rd_data : 8'h00;
        end
    end

    // ==========================================================
    // Checks.
    // ==========================================================
    a_idle_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        !cmd_busy |=> active_command_low == 8'h00 && active_command_high == 8'h00)
        else $error("Idle command bytes not zero");
    a_overflow_set: assert property (@(posedge core_clk) disable iff (!nrst)
        setup_arrive && ctrl_fifo_full |=> setup_overflow_flag && !setup_accept)
        else $error("Overflow not flagged");
    a_reset_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        device_reset_request && !(setup_arrive && ctrl_fifo_full) |=> !setup_overflow_flag)
        else $error("Overflow not cleared");
    a_zero_bit: assert property (@(posedge core_clk) disable iff (!nrst)
        rd_valid && $past(rd_addr) >= bsrr_pkg::OFS_RES_FIRST |-> !rd_data[bsrr_pkg::BIT_ZERO])
        else $error("Bit3 set");
    a_level_bound: assert property (@(posedge core_clk) disable iff (!nrst)
        command_queue_level <= CMD_TOP && outbound_queue_level <= DATA_TOP)
        else $error("Level beyond depth");
    a_level_step: assert property (@(posedge core_clk) disable iff (!nrst || device_reset_request)
        out_push && !out_pop && outbound_queue_level < DATA_TOP
        |=> outbound_queue_level == $past(outbound_queue_level) + 8'h01)
        else $error("Outbound level not counted");
    a_in_step: assert property (@(posedge core_clk) disable iff (!nrst || device_reset_request)
        in_pop && !in_push && inbound_queue_level != 8'h00
        |=> inbound_queue_level == $past(inbound_queue_level) - 8'h01)
        else $error("Inbound level not counted");
    a_short_kind: assert property (@(posedge core_clk) disable iff (!nrst)
        !(k_reset || k_path) |-> !error_byte[1])
        else $error("Short flag on wrong command");
    a_report_len: assert property (@(posedge core_clk) disable iff (!nrst)
        report_len <= 5'd16)
        else $error("Report too long");

    c_overflow: cover property (@(posedge core_clk) setup_drop);
    c_result: cover property (@(posedge core_clk) q_pop);
    c_detect: cover property (@(posedge core_clk) detect_ev && want_res);
    c_queue_full: cover property (@(posedge core_clk) q_full);

endmodule : bsrr_status_report

// ---- inc/bsrr_pkg.sv ----
package bsrr_pkg;

    // ==========================================================
    // Register offsets of the status report.
    // ==========================================================
    localparam logic [4:0] OFS_CMD_LOW   = 5'h09;  // Active command, first byte.
    localparam logic [4:0] OFS_CMD_HIGH  = 5'h0A;  // Active command, second byte.
    localparam logic [4:0] OFS_CMD_LEVEL = 5'h0B;  // Command queue fill level.
    localparam logic [4:0] OFS_OUT_LEVEL = 5'h0C;  // Outbound queue fill level.
    localparam logic [4:0] OFS_IN_LEVEL  = 5'h0D;  // Inbound queue fill level.
    localparam logic [4:0] OFS_TEST_A    = 5'h0E;  // Reserved test register.
    localparam logic [4:0] OFS_TEST_B    = 5'h0F;  // Reserved test register.
    localparam logic [4:0] OFS_RES_FIRST = 5'h10;  // First result byte.
    localparam logic [4:0] OFS_RES_LAST  = 5'h1F;  // Last result byte.

    // ==========================================================
    // Depths, reset values and result layout.
    // ==========================================================
    localparam int         CMD_DEPTH     = 16;     // Command queue depth.
    localparam int         DATA_DEPTH    = 128;    // Data queue depth.
    localparam int         RES_SLOTS     = 16;     // Result slots per report.
    localparam logic [7:0] IDLE_VALUE    = 8'h00;  // Command bytes while idle.
    localparam logic [7:0] DETECT_BYTE   = 8'hA5;  // Device detect result byte.
    localparam logic [7:0] ZERO_BYTE     = 8'h00;  // Reserved read value.
    localparam int         BIT_EOS       = 7;      // Early search end.
    localparam int         BIT_RDP       = 6;      // Redirected page.
    localparam int         BIT_CRC       = 5;      // Checksum error.
    localparam int         BIT_CMP       = 4;      // Compare error.
    localparam int         BIT_ZERO      = 3;      // Always zero.
    localparam int         BIT_APP       = 2;      // Alarm presence.
    localparam int         BIT_SHORT     = 1;      // Bus short.
    localparam int         BIT_NOPRES    = 0;      // No presence.

    // Command kinds reported by the bus engine on completion.
    typedef enum logic [2:0] {
        BSRR_K_OTHER    = 3'b000,
        BSRR_K_RESET    = 3'b001,
        BSRR_K_PATH     = 3'b010,
        BSRR_K_SEARCH   = 3'b011,
        BSRR_K_WRPAGE   = 3'b100,
        BSRR_K_RDCRC    = 3'b101,
        BSRR_K_RDREDIR  = 3'b110
    } bsrr_kind_t;

endpackage : bsrr_pkg

// ---- verilog/bsrr_result_queue.sv ----
`timescale 1ns/10ps

// ==============================================================
// Small queue of result bytes, kept in completion order.
// ==============================================================
module bsrr_result_queue #(
    parameter int DEPTH = 16
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       clear,
    input  wire logic       push,
    input  wire logic [7:0] push_data,
    input  wire logic       pop,
    output logic [7:0]      head,
    output logic            empty,
    output logic            full
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("DEPTH must be a power of two");
        end
    end

    logic [7:0]  mem [DEPTH];     // Byte storage.
    logic [AW:0] wr_ptr;          // Write pointer with wrap bit.
    logic [AW:0] rd_ptr;          // Read pointer with wrap bit.

    wire do_push = push && !full;
    wire do_pop  = pop && !empty;

    assign empty = (wr_ptr == rd_ptr);
    assign full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign head  = mem[rd_ptr[AW-1:0]];

    // Pointers advance once per accepted push or pop.
    always_ff @(posedge core_clk) begin
        if (!nrst || clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Storage has no reset; only written slots are ever read.
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= push_data;
        end
    end

endmodule : bsrr_result_queue

// ---- test/bsrr_host_model.sv ----
`timescale 1ns/10ps

// ==========================================================
// Host side: polls the status endpoint and reads the report.
// ==========================================================
module bsrr_host_model (
    input  wire logic       core_clk,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    input  wire logic [4:0] report_len,
    output logic            poll_start,
    output logic            rd_en,
    output logic [4:0]      rd_addr,
    output logic            device_reset_request
);
    // All requests idle at time zero.
    initial begin
        poll_start           = 1'b0;
        rd_en                = 1'b0;
        rd_addr              = 5'h00;
        device_reset_request = 1'b0;
    end

    // One read; the address is inverted when idle so a stale value never looks valid.
    task automatic read(input logic [4:0] a, output logic [7:0] d);
        int n;
        @(posedge core_clk) #1;
        rd_en   = 1'b1;
        rd_addr = a;
        @(posedge core_clk) #1;
        rd_en   = 1'b0;
        rd_addr = ~a;
        for (n = 0; n < 4 && rd_valid !== 1'b1; n++) begin
            @(posedge core_clk) #1;
        end
        d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
    endtask : read

    // Starts a poll and waits until the capture has settled.
    task automatic poll(output logic [4:0] len);
        int n;
        int same;
        @(posedge core_clk) #1;
        poll_start = 1'b1;
        @(posedge core_clk) #1;
        poll_start = 1'b0;
        same       = 0;
        len        = report_len;
        for (n = 0; n < 200 && same < 4; n++) begin
            @(posedge core_clk) #1;
            same = (report_len === len) ? same + 1 : 0;
            len  = report_len;
        end
    endtask : poll

    // The only way the host leaves the overflow state.
    task automatic reset_dev();
        @(posedge core_clk) #1;
        device_reset_request = 1'b1;
        @(posedge core_clk) #1;
        device_reset_request = 1'b0;
    endtask : reset_dev
endmodule : bsrr_host_model

// ---- test/tb_bridge_status_result_report.sv ----
`timescale 1ns/10ps

// ==========================================================
// Self-checking bench for the status and result report.
// ==========================================================
module tb_bridge_status_result_report;
    logic       core_clk, nrst, cmd_busy, cmd_push, cmd_pop, out_push, out_pop;
    logic       in_push, in_pop, setup_arrive, ctrl_fifo_full, cmd_done;
    logic       notify_result_bit, result_control_bit, device_detect;
    logic [7:0] cmd_byte_low, cmd_byte_high, ev;
    logic [2:0] done_kind;
    wire        poll_start, rd_en, rd_valid, setup_accept, setup_overflow_flag, dev_rst;
    wire  [4:0] rd_addr, report_len;
    wire  [7:0] rd_data;
    int         miscompares = 0;
    int         checks      = 0;

    bsrr_status_report DUT (
        .core_clk(core_clk), .nrst(nrst), .cmd_busy(cmd_busy), .cmd_byte_low(cmd_byte_low),
        .cmd_byte_high(cmd_byte_high), .cmd_push(cmd_push), .cmd_pop(cmd_pop),
        .out_push(out_push), .out_pop(out_pop), .in_push(in_push), .in_pop(in_pop),
        .setup_arrive(setup_arrive), .ctrl_fifo_full(ctrl_fifo_full),
        .device_reset_request(dev_rst), .cmd_done(cmd_done), .done_kind(done_kind),
        .notify_result_bit(notify_result_bit), .result_control_bit(result_control_bit),
        .ev_no_presence(ev[0]), .ev_short(ev[1]), .ev_alarm(ev[2]), .ev_crc_bad(ev[5]),
        .ev_redirect(ev[6]), .ev_compare(ev[4]), .ev_search_early(ev[7]),
        .device_detect(device_detect), .poll_start(poll_start), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .report_len(report_len), .setup_accept(setup_accept),
        .setup_overflow_flag(setup_overflow_flag));

    bsrr_host_model host (
        .core_clk(core_clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .report_len(report_len), .poll_start(poll_start), .rd_en(rd_en),
        .rd_addr(rd_addr), .device_reset_request(dev_rst));

    // 100 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic conclude();
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        host.read(a, d);
        chk(d, exp, what);
    endtask : rd_chk

    task automatic step();
        @(posedge core_clk) #1;
    endtask : step

    // Command bytes read zero while idle, the low byte even if the engine leaves it stale.
    task automatic t_command();
        rd_chk(bsrr_pkg::OFS_CMD_LOW, bsrr_pkg::IDLE_VALUE, "idle low");
        rd_chk(bsrr_pkg::OFS_CMD_HIGH, bsrr_pkg::IDLE_VALUE, "idle high");
        cmd_busy      = 1'b1;
        cmd_byte_low  = 8'h3C;
        cmd_byte_high = 8'hC3;
        rd_chk(bsrr_pkg::OFS_CMD_LOW, 8'h3C, "busy low");
        rd_chk(bsrr_pkg::OFS_CMD_HIGH, 8'hC3, "busy high");
        cmd_busy = 1'b0;
        rd_chk(bsrr_pkg::OFS_CMD_LOW, bsrr_pkg::IDLE_VALUE, "stale low");
        rd_chk(bsrr_pkg::OFS_TEST_A, bsrr_pkg::ZERO_BYTE, "reserved");
    endtask : t_command

    // Fill the command queue to its depth, then push and pop in one cycle.
    task automatic t_levels();
        for (int i = 0; i < 16; i++) begin
            cmd_push = 1'b1;
            out_push = 1'b1;
            in_push  = (i < 3);
            step();
        end
        {cmd_push, out_push, in_push} = 3'h0;
        rd_chk(bsrr_pkg::OFS_CMD_LEVEL, 8'h10, "cmd full");
        rd_chk(bsrr_pkg::OFS_OUT_LEVEL, 8'h10, "out level");
        rd_chk(bsrr_pkg::OFS_IN_LEVEL, 8'h03, "in level");
        {cmd_pop, in_pop, out_push, out_pop} = 4'hF;
        step();
        {cmd_pop, in_pop, out_push, out_pop} = 4'h0;
        rd_chk(bsrr_pkg::OFS_CMD_LEVEL, 8'h0F, "cmd pop");
        rd_chk(bsrr_pkg::OFS_OUT_LEVEL, 8'h10, "out push pop");
        rd_chk(bsrr_pkg::OFS_IN_LEVEL, 8'h02, "in pop");
    endtask : t_levels

    // A setup into a full control queue is dropped; only a reset request recovers.
    task automatic t_overflow();
        setup_arrive = 1'b1;
        step();
        chk({7'h00, setup_accept}, 8'h01, "accept");
        ctrl_fifo_full = 1'b1;
        step();
        chk({7'h00, setup_overflow_flag}, 8'h01, "overflow");
        chk({7'h00, setup_accept}, 8'h00, "dropped");
        {setup_arrive, ctrl_fifo_full} = 2'h0;
        host.reset_dev();
        chk({7'h00, setup_overflow_flag}, 8'h00, "recovered");
        rd_chk(bsrr_pkg::OFS_CMD_LEVEL, 8'h00, "reset level");
    endtask : t_overflow

    task automatic done(input logic [2:0] k, input logic [7:0] f, input logic n, input logic r);
        step();
        {done_kind, ev, notify_result_bit, result_control_bit} = {k, f, n, r};
        cmd_done = 1'b1;
        step();
        cmd_done = 1'b0;
    endtask : done

    // Mixed completions; only notified or flagged ones report, detect byte last.
    task automatic t_results();
        logic [7:0] exp [8] = '{8'h03, 8'h81, 8'h60, 8'h10, 8'h04, 8'h00, 8'h03, 8'hA5};
        logic [4:0] len;
        done(bsrr_pkg::BSRR_K_RESET, 8'h03, 1'b1, 1'b0);
        done(bsrr_pkg::BSRR_K_SEARCH, 8'h81, 1'b1, 1'b0);
        done(bsrr_pkg::BSRR_K_OTHER, 8'h00, 1'b0, 1'b1);
        done(bsrr_pkg::BSRR_K_RDREDIR, 8'h60, 1'b0, 1'b1);
        done(bsrr_pkg::BSRR_K_OTHER, 8'h10, 1'b1, 1'b0);
        done(bsrr_pkg::BSRR_K_RESET, 8'h04, 1'b1, 1'b0);
        done(bsrr_pkg::BSRR_K_WRPAGE, 8'h00, 1'b1, 1'b0);
        done(bsrr_pkg::BSRR_K_RDCRC, 8'h20, 1'b0, 1'b0);
        done(bsrr_pkg::BSRR_K_PATH, 8'h07, 1'b1, 1'b0);
        device_detect = 1'b1;
        step();
        device_detect = 1'b0;
        host.poll(len);
        chk({3'h0, len}, 8'h08, "result count");
        for (int i = 0; i < 8; i++) begin
            rd_chk(bsrr_pkg::OFS_RES_FIRST + 5'(i), exp[i], "result");
        end
        rd_chk(bsrr_pkg::OFS_RES_FIRST + 5'h08, bsrr_pkg::ZERO_BYTE, "past end");
        host.poll(len);
        chk({3'h0, len}, 8'h00, "second poll");
    endtask : t_results

    // Main sequence.
    initial begin
        {nrst, cmd_busy, cmd_push, cmd_pop, out_push, out_pop, in_push, in_pop} = 8'h00;
        {setup_arrive, ctrl_fifo_full, cmd_done, device_detect} = 4'h0;
        {notify_result_bit, result_control_bit, done_kind} = 5'h00;
        {cmd_byte_low, cmd_byte_high, ev} = 24'h000000;
        repeat (2) @(posedge core_clk);
        #1 nrst = 1'b1;
        t_command();
        t_levels();
        t_overflow();
        t_results();
        conclude();
    end

    // The whole run needs well under 2000 cycles.
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
endmodule : tb_bridge_status_result_report
